// ==== dram_nibble_host.sv ====
// Host controller driving a nibble-mode DRAM: init, refresh, bursts, test
// Behaviour
// - Further bits: CAS high then low, RAS low
// - CAS re-cycled after refresh enables test access
// - Test column latched on CAS fall, nine bits
// - Test procedure: init, lows, modify highs, complement
// - Hold RAS and CAS high during power-up
// - Eight RAS cycles after initial pause
// - Eight RAS cycles again after idle period
// - Any RAS cycle counts as initialisation; only RAS-only cycles in ST_RASONLY are counted here
// - Write enable low before CAS: early write
// - Every row refreshed within each interval
module dram_nibble_host #(
    parameter int IDLE_LIMIT = dram_host_pkg::IDLE_CYC,
    parameter int PAUSE_LIMIT = dram_host_pkg::PAUSE_CYC,
    parameter int REF_LIMIT = dram_host_pkg::REF_CYC
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic req,
    input wire logic [8:0] req_row,
    input wire logic [8:0] req_col,
    input wire logic [2:0] req_len,
    input wire logic [7:0] req_wmask,
    input wire logic [7:0] req_wdata,
    input wire logic test_req,
    input wire logic [8:0] test_col,
    input wire logic test_write,
    input wire logic test_wdata,
    output logic ready,
    output logic done,
    output logic [7:0] rdata,
    output logic init_done,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [8:0] mux_address_inputs,
    output logic dram_d,
    input wire logic dram_q
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    localparam int TW = dram_host_pkg::TMR_W;

    dram_host_pkg::state_t state_r;
    logic [TW-1:0] tmr_r;
    logic [dram_host_pkg::INIT_W-1:0] init_cnt_r;
    logic [dram_host_pkg::REF_W-1:0] ref_tmr_r;
    logic [dram_host_pkg::IDLE_W-1:0] idle_tmr_r;
    logic ref_pend_r;
    logic test_r;
    logic op_r;
    logic [2:0] beat_r;
    logic [2:0] len_r;
    logic [7:0] wmask_r;
    logic [7:0] wdata_r;
    logic [8:0] row_r;
    logic [8:0] col_r;
    logic [1:0] nibble_r;
    logic q_sync;

    wire phase_end = (tmr_r == '0);
    wire ref_tick = (ref_tmr_r == dram_host_pkg::REF_W'(REF_LIMIT - 1));
    wire idle_expired =
        (idle_tmr_r == dram_host_pkg::IDLE_W'(IDLE_LIMIT - 1));
    wire in_idle = (state_r == dram_host_pkg::ST_IDLE);
    wire start_ref = in_idle && init_done && ref_pend_r;
    wire start_test = in_idle && init_done && !ref_pend_r && test_req;
    wire start_req = in_idle && init_done && !ref_pend_r && !test_req && req;
    wire last_beat = (beat_r == len_r);
    wire next_we_n = !wmask_r[beat_r + 3'h1];
    wire next_d = wdata_r[beat_r + 3'h1];

    assign ready = in_idle && init_done && !ref_pend_r;

    // Phase length in cycles, zero-based for the down-counter
    function automatic logic [TW-1:0] cyc(input int n);
        cyc = TW'(n - 1);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Data output pin is asynchronous to core_clk
    dram_pin_sync #(
        .WIDTH(1)
    ) q_sync_inst (
        .core_clk(core_clk),
        .reset(reset),
        .pin(dram_q),
        .pin_sync(q_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // Refresh pacing and idle watch
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ref_tmr_r <= '0;
            ref_pend_r <= 1'b0;
        end else begin
            ref_tmr_r <= ref_tick ? '0 : ref_tmr_r + 1'b1;
            ref_pend_r <= ref_tick || (ref_pend_r && !start_ref);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset || !ras_n || idle_expired) begin
            idle_tmr_r <= '0;
        end else begin
            idle_tmr_r <= idle_tmr_r + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Strobe sequencer
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_r <= dram_host_pkg::ST_POWER;
            tmr_r <= cyc(PAUSE_LIMIT);
            init_cnt_r <= '0;
            init_done <= 1'b0;
            test_r <= 1'b0;
            op_r <= 1'b0;
            beat_r <= '0;
            len_r <= '0;
            wmask_r <= '0;
            wdata_r <= '0;
            row_r <= '0;
            col_r <= '0;
            nibble_r <= '0;
            rdata <= '0;
            done <= 1'b0;
            ras_n <= 1'b1;
            cas_n <= 1'b1;
            we_n <= 1'b1;
            mux_address_inputs <= '0;
            dram_d <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!phase_end) begin
                tmr_r <= tmr_r - 1'b1;
            end
            if (idle_expired) begin
                init_done <= 1'b0;
                init_cnt_r <= '0;
            end
            unique case (state_r)
                dram_host_pkg::ST_POWER: begin
                    if (phase_end) begin
                        state_r <= dram_host_pkg::ST_IDLE;
                    end
                end
                dram_host_pkg::ST_IDLE: begin
                    if (!init_done) begin
                        state_r <= dram_host_pkg::ST_RASONLY;
                        ras_n <= 1'b0;
                        tmr_r <= cyc(dram_host_pkg::PHASE_CYC);
                    end else if (start_ref || start_test) begin
                        state_r <= dram_host_pkg::ST_REF_CAS;
                        cas_n <= 1'b0;
                        test_r <= start_test;
                        op_r <= start_test;
                        len_r <= '0;
                        beat_r <= '0;
                        col_r <= test_col;
                        wmask_r <= {7'h00, test_write};
                        wdata_r <= {7'h00, test_wdata};
                        tmr_r <= cyc(dram_host_pkg::PHASE_CYC);
                    end else if (start_req) begin
                        state_r <= dram_host_pkg::ST_ROW;
                        op_r <= 1'b1;
                        test_r <= 1'b0;
                        row_r <= req_row;
                        col_r <= req_col;
                        len_r <= req_len;
                        wmask_r <= req_wmask;
                        wdata_r <= req_wdata;
                        beat_r <= '0;
                        rdata <= '0;
                        mux_address_inputs <= req_row;
                        tmr_r <= cyc(dram_host_pkg::ADDR_SETUP_CYC);
                    end
                end
                dram_host_pkg::ST_RASONLY: begin
                    if (phase_end) begin
                        state_r <= dram_host_pkg::ST_PRE;
                        ras_n <= 1'b1;
                        init_cnt_r <= init_cnt_r + 1'b1;
                        if (init_cnt_r == dram_host_pkg::INIT_W'(
                            dram_host_pkg::INIT_CYCLES - 1)) begin
                            init_done <= 1'b1;
                        end
                        tmr_r <= cyc(dram_host_pkg::PHASE_CYC);
                    end
                end
                dram_host_pkg::ST_ROW: begin
                    ras_n <= 1'b0;
                    if (!ras_n && phase_end) begin
                        state_r <= dram_host_pkg::ST_COLSET;
                        mux_address_inputs <= col_r;
                        we_n <= !wmask_r[0];
                        dram_d <= wdata_r[0];
                        nibble_r <= {row_r[dram_host_pkg::TOP_BIT],
                            col_r[dram_host_pkg::TOP_BIT]};
                        tmr_r <= cyc(dram_host_pkg::ADDR_SETUP_CYC);
                    end else if (ras_n) begin
                        tmr_r <= cyc(dram_host_pkg::PHASE_CYC);
                    end
                end
                dram_host_pkg::ST_COLSET: begin
                    if (phase_end) begin
                        state_r <= dram_host_pkg::ST_COL;
                        cas_n <= 1'b0;
                        tmr_r <= cyc(dram_host_pkg::CAS_LOW_CYC);
                    end
                end
                dram_host_pkg::ST_COL: begin
                    if (phase_end) begin
                        if (wmask_r[beat_r]) begin
                            rdata[beat_r] <= wdata_r[beat_r];
                        end else begin
                            rdata[beat_r] <= q_sync;
                        end
                        cas_n <= 1'b1;
                        tmr_r <= cyc(dram_host_pkg::PHASE_CYC);
                        if (last_beat) begin
                            state_r <= dram_host_pkg::ST_PRE;
                            ras_n <= 1'b1;
                            we_n <= 1'b1;
                        end else begin
                            state_r <= dram_host_pkg::ST_CASHI;
                            we_n <= next_we_n;
                            dram_d <= next_d;
                            beat_r <= beat_r + 3'h1;
                            nibble_r <= nibble_r + 2'h1;
                        end
                    end
                end
                dram_host_pkg::ST_CASHI: begin
                    if (phase_end) begin
                        state_r <= dram_host_pkg::ST_COL;
                        cas_n <= 1'b0;
                        tmr_r <= cyc(dram_host_pkg::CAS_LOW_CYC);
                    end
                end
                dram_host_pkg::ST_REF_CAS: begin
                    if (phase_end) begin
                        state_r <= dram_host_pkg::ST_REF_RAS;
                        ras_n <= 1'b0;
                        tmr_r <= cyc(dram_host_pkg::CAS_LOW_CYC);
                    end
                end
                dram_host_pkg::ST_REF_RAS: begin
                    if (phase_end) begin
                        cas_n <= 1'b1;
                        tmr_r <= cyc(dram_host_pkg::PHASE_CYC);
                        if (test_r) begin
                            state_r <= dram_host_pkg::ST_TST_HI;
                            mux_address_inputs <= col_r;
                            we_n <= !wmask_r[0];
                            dram_d <= wdata_r[0];
                        end else begin
                            state_r <= dram_host_pkg::ST_PRE;
                            ras_n <= 1'b1;
                        end
                    end
                end
                dram_host_pkg::ST_TST_HI: begin
                    if (phase_end) begin
                        state_r <= dram_host_pkg::ST_COL;
                        cas_n <= 1'b0;
                        tmr_r <= cyc(dram_host_pkg::CAS_LOW_CYC);
                    end
                end
                dram_host_pkg::ST_PRE: begin
                    if (phase_end) begin
                        state_r <= dram_host_pkg::ST_IDLE;
                        done <= op_r;
                        op_r <= 1'b0;
                        test_r <= 1'b0;
                    end
                end
                default: begin
                    state_r <= dram_host_pkg::ST_IDLE;
                end
            endcase
        end
    end

endmodule

// ==== dram_host_pkg.sv ====
// Constants and state codes for the nibble-mode DRAM host controller
package dram_host_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int PAUSE_NS = 100_000;
    localparam int PAUSE_CYC = (PAUSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REFRESH_WINDOW_NS = 4_000_000;
    localparam int REFRESH_ROWS = 256;
    localparam int REF_CYC = REFRESH_WINDOW_NS / REFRESH_ROWS / CLK_PERIOD_NS;
    localparam int IDLE_LIMIT_NS = 4_000_000;
    localparam int IDLE_CYC = IDLE_LIMIT_NS / CLK_PERIOD_NS;
    localparam int PHASE_NS = 200;
    localparam int PHASE_CYC = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CAS_LOW_NS = 400;
    localparam int CAS_LOW_CYC =
        (CAS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ADDR_SETUP_CYC = 1;
    localparam int INIT_CYCLES = 8;

    ////////////////////////////////////////////////////////////////////////
    // Widths and field positions
    localparam int ADDR_W = 9;
    localparam int TOP_BIT = 8;
    localparam int TMR_W = 10;
    localparam int REF_W = 8;
    localparam int IDLE_W = 16;
    localparam int INIT_W = 4;

    ////////////////////////////////////////////////////////////////////////
    // Controller states
    typedef enum logic [3:0] {
        ST_POWER   = 4'h0,
        ST_RASONLY = 4'h1,
        ST_ROW     = 4'h2,
        ST_COLSET  = 4'h3,
        ST_COL     = 4'h4,
        ST_CASHI   = 4'h5,
        ST_PRE     = 4'h6,
        ST_IDLE    = 4'h7,
        ST_REF_CAS = 4'h8,
        ST_REF_RAS = 4'h9,
        ST_TST_HI  = 4'ha
    } state_t;

endpackage

// ==== dram_pin_sync.sv ====
// Two-flop synchroniser for pins arriving from outside the clock domain
module dram_pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] pin_sync
);

    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            meta_r <= '0;
            pin_sync <= '0;
        end else begin
            meta_r <= pin;
            pin_sync <= meta_r;
        end
    end

endmodule

// ==== dram_host_properties.sv ====
// Concurrent checks on the pins of the nibble DRAM host controller
module dram_host_properties #(
    parameter int PAUSE_LIMIT = 20,
    parameter int REF_LIMIT = 60
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic ready,
    input wire logic init_done,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [8:0] mux_address_inputs,
    input wire logic dram_d
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] up_cnt_r;
    logic [15:0] gap_r;
    logic [3:0] falls_r;
    logic ras_q_r;
    logic ras_fall;
    assign ras_fall = ras_q_r & ~ras_n;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            up_cnt_r <= 16'h0000;
            gap_r <= 16'h0000;
            falls_r <= 4'h0;
            ras_q_r <= 1'b1;
        end else begin
            ras_q_r <= ras_n;
            if (up_cnt_r != 16'hffff) up_cnt_r <= up_cnt_r + 16'h0001;
            gap_r <= ras_fall ? 16'h0000 : gap_r + 16'h0001;
            if (ras_fall && falls_r != 4'hf) falls_r <= falls_r + 4'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    chk_powerup_strobes_high: assert property (
        up_cnt_r < PAUSE_LIMIT |-> ras_n && cas_n) else $error("strobe low");
    chk_init_eight_ras: assert property (
        $rose(init_done) |-> falls_r == 4'h8) else $error("init count");
    chk_ready_needs_init: assert property (
        ready |-> init_done && ras_n && cas_n) else $error("ready early");
    chk_ras_gap_bound: assert property (
        init_done |-> gap_r < 2 * REF_LIMIT) else $error("refresh late");
    chk_cas_retoggle: assert property (
        $rose(cas_n) && !ras_n |-> !ras_n [*3] ##0 !cas_n)
        else $error("cas toggle");
    chk_col_addr_held: assert property (
        $fell(cas_n) && !ras_n |-> $stable(mux_address_inputs))
        else $error("column setup");
    chk_early_write_setup: assert property (
        $fell(cas_n) && !ras_n |-> $stable(we_n) && $stable(dram_d))
        else $error("write setup");
    chk_row_addr_held: assert property (
        $fell(ras_n) && cas_n |-> $stable(mux_address_inputs))
        else $error("row setup");
    chk_cbr_cas_first: assert property (
        $fell(ras_n) && !cas_n |-> !$past(cas_n)) else $error("cbr setup");
endmodule

bind dram_nibble_host dram_host_properties #(
    .PAUSE_LIMIT(PAUSE_LIMIT), .REF_LIMIT(REF_LIMIT)
) chk (
    .core_clk(core_clk), .reset(reset), .ready(ready),
    .init_done(init_done), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .mux_address_inputs(mux_address_inputs), .dram_d(dram_d)
);

// ==== dram_nibble_model.sv ====
// Behavioural nibble-mode DRAM with a CAS-before-RAS row counter
module dram_nibble_model (
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [8:0] mux_address_inputs,
    input wire logic dram_d,
    output logic dram_q
);
    timeunit 1ns;
    timeprecision 1ns;
    bit mem [0:262143];
    logic [8:0] row_r;
    logic [7:0] col_r;
    logic [1:0] nib_r;
    logic [7:0] cnt_r = 8'h00;
    logic [17:0] idx;
    logic first_r = 1'b1;
    initial dram_q = 1'b0;
    always @(negedge ras_n) begin
        if (!cas_n) begin
            row_r = {1'b1, cnt_r};
            cnt_r = cnt_r + 8'h01;
        end else begin
            row_r = mux_address_inputs;
        end
    end
    always @(posedge ras_n) first_r = 1'b1;
    always @(negedge cas_n) begin
        if (!ras_n) begin
            if (first_r) begin
                col_r = mux_address_inputs[7:0];
                nib_r = {row_r[8], mux_address_inputs[8]};
                first_r = 1'b0;
            end else begin
                nib_r = nib_r + 2'h1;
            end
            idx = {nib_r[1], row_r[7:0], nib_r[0], col_r};
            if (!we_n) begin
                mem[idx] = dram_d;
                dram_q = ~dram_q;
            end else begin
                dram_q = mem[idx];
            end
        end
    end
    // Released output toggles so a stale bit never passes for data
    always @(posedge cas_n) dram_q = ~dram_q;
endmodule

// ==== tb_dram_nibble_and_refresh_test.sv ====
// Self-checking bench: host controller against a behavioural nibble DRAM
module tb_dram_nibble_and_refresh_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, reset, req, test_req, test_write, test_wdata;
    logic [8:0] req_row, req_col, test_col, mux_address_inputs;
    logic [2:0] req_len;
    logic [7:0] req_wmask, req_wdata, rdata, cbr_cnt;
    logic ready, done, init_done, ras_n, cas_n, we_n, dram_d, dram_q;
    logic [15:0] exp_q[$];
    bit shadow [0:262143];
    int n_errors, check_count;

    dram_nibble_host #(.IDLE_LIMIT(200), .PAUSE_LIMIT(20), .REF_LIMIT(60))
    dut (.core_clk(core_clk), .reset(reset), .req(req), .req_row(req_row),
        .req_col(req_col), .req_len(req_len), .req_wmask(req_wmask),
        .req_wdata(req_wdata), .test_req(test_req), .test_col(test_col),
        .test_write(test_write), .test_wdata(test_wdata), .ready(ready),
        .done(done), .rdata(rdata), .init_done(init_done), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .mux_address_inputs(mux_address_inputs),
        .dram_d(dram_d), .dram_q(dram_q));
    dram_nibble_model mem_model (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .mux_address_inputs(mux_address_inputs), .dram_d(dram_d),
        .dram_q(dram_q));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen,
            input logic [7:0] want);
        check_count++;
        if (seen !== want) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic final_report();
        if (n_errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Bounded wait: 0 ready, 1 done, 2 row strobe low
    task automatic wait_on(input int sel);
        for (int i = 0; i < 3000; i++) begin
            @(posedge core_clk);
            if (sel == 0 && ready === 1'b1) return;
            if (sel == 1 && done === 1'b1) return;
            if (sel == 2 && ras_n === 1'b0) return;
        end
        n_errors++;
        final_report();
    endtask
    task automatic take();
        wait_on(0);
        req <= 1'b0;
        test_req <= 1'b0;
    endtask
    task automatic burst(input logic [8:0] row, input logic [8:0] col,
            input logic [2:0] len, input logic [7:0] wm, input logic [7:0] wd);
        logic [7:0] e;
        logic [1:0] nb;
        logic [17:0] ix;
        e = 8'h00;
        nb = {row[8], col[8]};
        for (int k = 0; k <= int'(len); k++) begin
            ix = {nb[1], row[7:0], nb[0], col[7:0]};
            if (wm[k]) shadow[ix] = wd[k];
            e[k] = shadow[ix];
            nb = nb + 2'h1;
        end
        exp_q.push_back({8'hff, e});
        req_row <= row;
        req_col <= col;
        req_len <= len;
        req_wmask <= wm;
        req_wdata <= wd;
        req <= 1'b1;
        take();
        wait_on(1);
    endtask
    task automatic test_op(input logic [8:0] col, input logic wr,
            input logic wd);
        logic [17:0] ix;
        test_col <= col;
        test_write <= wr;
        test_wdata <= wd;
        test_req <= 1'b1;
        take();
        wait_on(2);
        ix = {1'b1, 8'(cbr_cnt - 8'h01), col};
        if (wr) shadow[ix] = wd;
        // Test result lands in rdata[0] for reads and writes alike
        exp_q.push_back({8'h01, 7'h00, shadow[ix]});
        wait_on(1);
    endtask
    // Counts CAS-before-RAS events as the device counter sees them
    always @(negedge ras_n) begin
        if (cas_n === 1'b0) cbr_cnt = cbr_cnt + 8'h01;
    end
    always @(posedge core_clk) begin : result_watch
        logic [15:0] e;
        if (done === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("queue", 8'h01, 8'h00);
            end
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 16'h0000;
            check("rdata", rdata & e[15:8], e[7:0]);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [8:0] tc;
        n_errors = 0;
        check_count = 0;
        cbr_cnt = 8'h00;
        {reset, req, test_req, test_write, test_wdata} = 5'h10;
        {req_row, req_col, test_col} = 27'h0000000;
        {req_len, req_wmask, req_wdata} = 19'h00000;
        void'($urandom(32'he4a42290));
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        wait_on(0);
        check("init_done", {7'h00, init_done}, 8'h01);
        burst(9'h1ff, 9'h1ff, 3'h7, 8'hff, 8'h5a);
        burst(9'h1ff, 9'h1ff, 3'h7, 8'h00, 8'h00);
        burst(9'h0a3, 9'h17c, 3'h5, 8'h06, 8'h02);
        for (int i = 0; i < 40; i++) begin
            burst(9'($urandom) & 9'h103, 9'($urandom) & 9'h107,
                3'($urandom), 8'($urandom), 8'($urandom));
        end
        for (int p = 0; p < 2; p++) begin
            tc = 9'($urandom);
            for (int i = 0; i < 8; i++) begin
                test_op(tc, 1'b0, 1'b0);
            end
            for (int s = 0; s < 4; s++) begin
                for (int i = 0; i < 256; i++) begin
                    test_op(tc, !s[0], 1'(p) ^ s[1]);
                end
            end
        end
        // Let the watcher take the last result before counting leftovers
        @(posedge core_clk);
        check("pending", 8'(exp_q.size()), 8'h00);
        final_report();
    end
endmodule
